// >>> hw/cogc_pkg.sv
// package for the channel 1 output group control block
// assumes an apb slave with 32-bit data, byte offsets scaled by four
package cogc_pkg;
   // register indices as printed; byte address is four times the index
   localparam logic [15:0] COGC_IDX_PWR_CAL = 16'h2200;
   localparam logic [15:0] COGC_IDX_GROUP = 16'h2201;
   localparam logic [17:0] COGC_ADDR_PWR_CAL = {COGC_IDX_PWR_CAL, 2'b00};
   localparam logic [17:0] COGC_ADDR_GROUP = {COGC_IDX_GROUP, 2'b00};
   localparam logic [7:0] COGC_RST_PWR_CAL = 8'h00;
   localparam logic [7:0] COGC_RST_GROUP = 8'h00;
   localparam logic [7:0] COGC_MASK_PWR_CAL = 8'h03;
   localparam logic [7:0] COGC_MASK_GROUP = 8'h0F;
   localparam int COGC_BIT_PWRDN = 0;
   localparam int COGC_BIT_CAL = 1;
   localparam int COGC_BIT_BURST = 0;
   localparam int COGC_BIT_MUTE = 1;
   localparam int COGC_BIT_RESET = 2;
   localparam int COGC_BIT_SYNC = 3;
   localparam int COGC_NUM_OUT = 4;
   localparam int COGC_PHASE_W = 2;
   typedef enum logic [1:0] {
      COGC_DRV_RUN = 2'b00,
      COGC_DRV_WAIT_MUTE = 2'b01,
      COGC_DRV_MUTED = 2'b10,
      COGC_DRV_WAIT_RUN = 2'b11
   } cogc_drv_state_t;
endpackage

// >>> hw/cogc_shadow.sv
// shadow buffer: a written value passes on only at the update strobe
// assumes the update strobe is a one-cycle pulse on i_mclk
`timescale 1ns/10ps
module cogc_shadow (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_update,
   input wire logic i_value,
   output logic o_value
);
   import cogc_pkg::*;
   logic value_q;
   logic value_d;
   always_comb begin
      value_d = i_update ? i_value : value_q;
   end
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         value_q <= 1'b0;
      end else begin
         value_q <= value_d;
      end
   end
   assign o_value = value_q;
endmodule

// >>> hw/cogc_driver.sv
// one output driver mute sequencer, runt free by waiting for a low phase, except that i_mute_now mutes at once
// assumes i_phase is the divided clock level of this output
`timescale 1ns/10ps
module cogc_driver (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_phase,
   input wire logic i_mute_now,
   input wire logic i_mute_safe,
   output logic o_muted
);
   import cogc_pkg::*;
   cogc_drv_state_t state_q;
   cogc_drv_state_t state_d;
   always_comb begin
      state_d = state_q;
      case (state_q)
         COGC_DRV_RUN: begin
            if (i_mute_now) begin
               state_d = COGC_DRV_MUTED;
            end else if (i_mute_safe) begin
               state_d = COGC_DRV_WAIT_MUTE;
            end
         end
         COGC_DRV_WAIT_MUTE: begin
            if (i_mute_now || !i_phase) begin
               state_d = COGC_DRV_MUTED;
            end else if (!i_mute_safe) begin
               state_d = COGC_DRV_RUN;
            end
         end
         COGC_DRV_MUTED: begin
            if (!i_mute_now && !i_mute_safe) begin
               state_d = COGC_DRV_WAIT_RUN;
            end
         end
         COGC_DRV_WAIT_RUN: begin
            if (i_mute_now || i_mute_safe) begin
               state_d = COGC_DRV_MUTED;
            end else if (!i_phase) begin
               state_d = COGC_DRV_RUN;
            end
         end
         default: begin
            state_d = COGC_DRV_MUTED;
         end
      endcase
   end
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         state_q <= COGC_DRV_RUN;
      end else begin
         state_q <= state_d;
      end
   end
   assign o_muted = (state_q == COGC_DRV_MUTED) || (state_q == COGC_DRV_WAIT_RUN);
endmodule

// >>> hw/cogc_top.sv
// channel 1 output group control: apb registers, calibration, drivers
// assumes apb master on i_mclk and an update strobe from the device
`timescale 1ns/10ps
module cogc_top (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [31:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [3:0] i_pstrb,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic i_io_update,
   input wire logic [cogc_pkg::COGC_NUM_OUT-1:0] i_out_phase,
   output logic o_vco_cal_start,
   output logic o_channel_power_down,
   output logic o_divider_reset,
   output logic o_burst_request,
   output logic [cogc_pkg::COGC_NUM_OUT-1:0] o_out_p,
   output logic [cogc_pkg::COGC_NUM_OUT-1:0] o_out_n,
   output logic [cogc_pkg::COGC_NUM_OUT-1:0] o_out_oe
);
   import cogc_pkg::*;
   logic [7:0] pwr_cal_q;
   logic [7:0] pwr_cal_d;
   logic [7:0] group_q;
   logic [7:0] group_d;
   logic [31:0] prdata_q;
   logic [31:0] prdata_d;
   logic pready_q;
   logic pready_d;
   logic pslverr_q;
   logic pslverr_d;
   logic cal_armed_q;
   logic cal_armed_d;
   logic cal_start_q;
   logic cal_start_d;
   logic pwrdn_q;
   logic pwrdn_d;
   logic divrst_q;
   logic divrst_d;
   logic burst_q;
   logic burst_d;
   logic burst_shadow;
   logic [COGC_NUM_OUT-1:0] muted;
   logic [COGC_NUM_OUT-1:0] out_p_q;
   logic [COGC_NUM_OUT-1:0] out_p_d;
   logic [COGC_NUM_OUT-1:0] out_n_q;
   logic [COGC_NUM_OUT-1:0] out_n_d;
   logic [COGC_NUM_OUT-1:0] out_oe_q;
   logic [COGC_NUM_OUT-1:0] out_oe_d;
   logic setup;
   logic access;
   logic hit_pc;
   logic hit_gr;
   logic [17:0] word_addr;
   logic sync_on;
   logic [COGC_NUM_OUT-1:0] phase_gated;

   // apb slave, one wait-free access phase
   always_comb begin
      word_addr = i_paddr[17:0];
      setup = i_psel && !i_penable;
      access = i_psel && i_penable;
      hit_pc = (word_addr == COGC_ADDR_PWR_CAL) && (i_paddr[31:18] == 14'h0000);
      hit_gr = (word_addr == COGC_ADDR_GROUP) && (i_paddr[31:18] == 14'h0000);
      pwr_cal_d = pwr_cal_q;
      group_d = group_q;
      prdata_d = prdata_q;
      pready_d = 1'b0;
      pslverr_d = 1'b0;
      if (setup) begin
         pready_d = 1'b1;
         pslverr_d = !(hit_pc || hit_gr);
         prdata_d = 32'h0000_0000;
         if (!i_pwrite && hit_pc) begin
            prdata_d = {24'h00_0000, pwr_cal_q};
         end else if (!i_pwrite && hit_gr) begin
            prdata_d = {24'h00_0000, group_q};
         end
      end
      if (access && pready_q && i_pwrite && i_pstrb[0]) begin
         if (hit_pc) begin
            pwr_cal_d = i_pwdata[7:0] & COGC_MASK_PWR_CAL;
         end
         if (hit_gr) begin
            group_d = i_pwdata[7:0] & COGC_MASK_GROUP;
         end
      end
   end

   // calibration trigger, channel power and divider hold
   always_comb begin
      cal_armed_d = cal_armed_q;
      cal_start_d = 1'b0;
      if (i_io_update && cal_armed_q) begin
         cal_start_d = 1'b1;
         cal_armed_d = 1'b0;
      end
      if (pwr_cal_d[COGC_BIT_CAL] && !pwr_cal_q[COGC_BIT_CAL]) begin
         cal_armed_d = 1'b1;
      end
      pwrdn_d = pwr_cal_q[COGC_BIT_PWRDN];
      divrst_d = group_q[COGC_BIT_SYNC];
      burst_d = burst_shadow;
   end

   cogc_shadow u_burst_shadow (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_update(i_io_update),
      .i_value(group_q[COGC_BIT_BURST]),
      .o_value(burst_shadow)
   );

   assign sync_on = group_q[COGC_BIT_SYNC];

   genvar g;
   generate
      for (g = 0; g < COGC_NUM_OUT; g++) begin : g_drv
         // sync holds the phase low; on release each output waits for its own low phase to unmute
         assign phase_gated[g] = i_out_phase[g] && !sync_on;
         cogc_driver u_drv (
            .i_mclk(i_mclk),
            .i_rst(i_rst),
            .i_phase(phase_gated[g]),
            .i_mute_now(group_q[COGC_BIT_RESET] || sync_on),
            .i_mute_safe(group_q[COGC_BIT_MUTE]),
            .o_muted(muted[g])
         );
      end
   endgenerate

   // output legs: muted is p low n high, powered down is tristate
   always_comb begin
      for (int i = 0; i < COGC_NUM_OUT; i++) begin
         out_oe_d[i] = !pwr_cal_q[COGC_BIT_PWRDN];
         if (muted[i] || sync_on) begin
            out_p_d[i] = 1'b0;
            out_n_d[i] = 1'b1;
         end else begin
            out_p_d[i] = i_out_phase[i];
            out_n_d[i] = !i_out_phase[i];
         end
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         pwr_cal_q <= COGC_RST_PWR_CAL;
         group_q <= COGC_RST_GROUP;
         prdata_q <= 32'h0000_0000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         cal_armed_q <= 1'b0;
         cal_start_q <= 1'b0;
         pwrdn_q <= 1'b0;
         divrst_q <= 1'b0;
         burst_q <= 1'b0;
         out_p_q <= '0;
         out_n_q <= '1;
         out_oe_q <= '1;
      end else begin
         pwr_cal_q <= pwr_cal_d;
         group_q <= group_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
         cal_armed_q <= cal_armed_d;
         cal_start_q <= cal_start_d;
         pwrdn_q <= pwrdn_d;
         divrst_q <= divrst_d;
         burst_q <= burst_d;
         out_p_q <= out_p_d;
         out_n_q <= out_n_d;
         out_oe_q <= out_oe_d;
      end
   end

   assign o_prdata = prdata_q;
   assign o_pready = pready_q;
   assign o_pslverr = pslverr_q;
   assign o_vco_cal_start = cal_start_q;
   assign o_channel_power_down = pwrdn_q;
   assign o_divider_reset = divrst_q;
   assign o_burst_request = burst_q;
   assign o_out_p = out_p_q;
   assign o_out_n = out_n_q;
   assign o_out_oe = out_oe_q;
endmodule

// >>> verif/cogc_top_sva.sv
// checker for the channel 1 output group control block
// bound to cogc_top, sees only its ports
`timescale 1ns/10ps
module cogc_top_sva (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic [31:0] i_paddr,
   input wire logic i_io_update,
   input wire logic [31:0] o_prdata,
   input wire logic o_pready,
   input wire logic o_pslverr,
   input wire logic o_vco_cal_start,
   input wire logic o_channel_power_down,
   input wire logic o_divider_reset,
   input wire logic o_burst_request,
   input wire logic [cogc_pkg::COGC_NUM_OUT-1:0] o_out_p,
   input wire logic [cogc_pkg::COGC_NUM_OUT-1:0] o_out_n,
   input wire logic [cogc_pkg::COGC_NUM_OUT-1:0] o_out_oe
);
   import cogc_pkg::*;
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   chk_ready_next: assert property (i_psel && !i_penable |=> o_pready)
      else $error("ready missing after setup");
   chk_unmapped_err: assert property (o_pready && i_paddr != {14'h0, COGC_ADDR_PWR_CAL}
      && i_paddr != {14'h0, COGC_ADDR_GROUP} |-> o_pslverr && o_prdata == 32'h0)
      else $error("unmapped access not refused");
   chk_reserved_zero: assert property (o_pready |-> o_prdata[31:4] == 28'h0)
      else $error("reserved bits not zero");
   chk_cal_single: assert property (o_vco_cal_start |-> $past(i_io_update) ##1 !o_vco_cal_start)
      else $error("calibration start not a single pulse after update");
   chk_oe_powerdown: assert property (o_out_oe == {4{!o_channel_power_down}})
      else $error("output enable disagrees with power down");
   chk_sync_muted: assert property (o_divider_reset [*2] |-> o_out_p == 4'h0 && o_out_n == 4'hF)
      else $error("drivers not muted while sync");
   chk_legs_diff: assert property (o_out_oe == 4'hF |-> o_out_p == ~o_out_n)
      else $error("legs not complementary");
   chk_burst_shadow: assert property ($changed(o_burst_request) |-> $past(i_io_update, 2))
      else $error("burst request moved without update");
endmodule
bind cogc_top cogc_top_sva u_sva (.i_mclk(i_mclk), .i_rst(i_rst), .i_psel(i_psel),
   .i_penable(i_penable), .i_paddr(i_paddr), .i_io_update(i_io_update), .o_prdata(o_prdata),
   .o_pready(o_pready), .o_pslverr(o_pslverr), .o_vco_cal_start(o_vco_cal_start),
   .o_channel_power_down(o_channel_power_down), .o_divider_reset(o_divider_reset),
   .o_burst_request(o_burst_request), .o_out_p(o_out_p), .o_out_n(o_out_n), .o_out_oe(o_out_oe));

// >>> verif/tb_cogc_top.sv
// self-checking bench for cogc_top with a small register model
// drives apb, update strobe and output phases itself
`timescale 1ns/10ps
module tb_cogc_top;
   import cogc_pkg::*;
   localparam logic [31:0] A0 = {14'h0, COGC_ADDR_PWR_CAL};
   localparam logic [31:0] A1 = {14'h0, COGC_ADDR_GROUP};
   logic i_mclk = 0, i_rst = 1, i_psel = 0, i_penable = 0, i_pwrite = 0, i_io_update = 0;
   logic [31:0] i_paddr = 0, i_pwdata = 0, o_prdata, rd, m0 = 0, m1 = 0;
   logic [3:0] i_pstrb = 4'hF, i_out_phase = 4'h0, o_out_p, o_out_n, o_out_oe;
   logic o_pready, o_pslverr, o_vco_cal_start, o_channel_power_down;
   logic o_divider_reset, o_burst_request;
   int fail_count = 0, checks = 0, seed = 9, arm = 0;
   always #4 i_mclk = ~i_mclk;
   cogc_top dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
      .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb),
      .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
      .i_io_update(i_io_update), .i_out_phase(i_out_phase), .o_vco_cal_start(o_vco_cal_start),
      .o_channel_power_down(o_channel_power_down), .o_divider_reset(o_divider_reset),
      .o_burst_request(o_burst_request), .o_out_p(o_out_p), .o_out_n(o_out_n),
      .o_out_oe(o_out_oe));
   task automatic complete_run;
      if (fail_count == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic idle(input int k);
      repeat (k) @(posedge i_mclk);
   endtask
   task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge i_mclk);
      i_psel <= 1'b1;
      i_pwrite <= wr;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_mclk);
      i_penable <= 1'b1;
      do begin
         @(posedge i_mclk);
         k++;
      end while (o_pready !== 1'b1 && k < 20);
      rd = o_prdata;
      chk(o_pready, 1);
      chk(o_pslverr, a != A0 && a != A1);
      if (!wr) chk(rd, a == A0 ? m0 : a == A1 ? m1 : 32'h0);
      if (wr && i_pstrb[0] && a == A0) begin
         if (!m0[COGC_BIT_CAL] && d[COGC_BIT_CAL]) arm = 1;
         m0 = d & {24'h0, COGC_MASK_PWR_CAL};
      end
      if (wr && i_pstrb[0] && a == A1) m1 = d & {24'h0, COGC_MASK_GROUP};
      i_psel <= 1'b0;
      i_penable <= 1'b0;
   endtask
   task automatic upd;
      int c;
      c = 0;
      @(posedge i_mclk);
      i_io_update <= 1'b1;
      @(posedge i_mclk);
      i_io_update <= 1'b0;
      repeat (4) begin
         @(posedge i_mclk);
         c += int'(o_vco_cal_start === 1'b1);
      end
      chk(c, arm);
      arm = 0;
   endtask
   initial begin
      #100000;
      fail_count++;
      complete_run();
   end
   initial begin
      idle(8);
      i_rst <= 1'b0;
      idle(1);
      chk({o_out_oe, o_out_n, o_out_p}, 12'hFF0);
      apb(0, A0, 0);
      apb(0, A1, 0);
      repeat (6) begin
         apb(1, A0, $random(seed));
         apb(0, A0, 0);
         apb(1, A1, $random(seed));
         apb(0, A1, 0);
      end
      apb(0, 32'h8808, 0);
      i_pstrb <= 4'h0;
      apb(1, A1, 32'hF);
      i_pstrb <= 4'hF;
      apb(0, A1, 0);
      apb(1, A1, 0);
      upd();
      apb(1, A0, 1);
      idle(2);
      chk({o_out_oe, 3'h0, o_channel_power_down}, 8'h01);
      apb(1, A0, 2);
      upd();
      apb(1, A0, 2);
      upd();
      apb(0, A0, 0);
      apb(1, A0, 0);
      apb(1, A0, 2);
      upd();
      apb(1, A1, 1);
      idle(3);
      chk(o_burst_request, 0);
      upd();
      chk(o_burst_request, 1);
      apb(1, A1, 0);
      upd();
      chk(o_burst_request, 0);
      apb(1, A1, 8);
      idle(3);
      chk({o_divider_reset, o_out_p, o_out_n}, 9'h10F);
      i_out_phase <= 4'hF;
      idle(3);
      chk(o_out_p, 0);
      i_out_phase <= 4'h0;
      apb(1, A1, 0);
      idle(3);
      i_out_phase <= 4'hF;
      idle(3);
      chk(o_out_p, 4'hF);
      apb(1, A1, 4);
      idle(3);
      chk(o_out_p, 0);
      apb(1, A1, 0);
      idle(3);
      chk(o_out_p, 0);
      i_out_phase <= 4'h0;
      idle(3);
      i_out_phase <= 4'hF;
      idle(3);
      chk(o_out_p, 4'hF);
      apb(1, A1, 2);
      idle(3);
      chk(o_out_p, 4'hF);
      i_out_phase <= 4'h0;
      idle(3);
      i_out_phase <= 4'hF;
      idle(3);
      chk({o_out_p, o_out_n}, 8'h0F);
      i_rst <= 1'b1;
      idle(3);
      i_rst <= 1'b0;
      m0 = 0;
      m1 = 0;
      arm = 0;
      idle(1);
      chk({o_out_oe, o_out_n, o_out_p}, 12'hFF0);
      chk({o_channel_power_down, o_divider_reset, o_burst_request}, 0);
      apb(0, A0, 0);
      apb(0, A1, 0);
      complete_run();
   end
endmodule
